//--- logic/wsq_regs.svh
`ifndef WSQ_REGS_SVH
`define WSQ_REGS_SVH

// Register byte offsets
`define WSQ_A_CTRL    8'h00
`define WSQ_A_STATUS  8'h04
`define WSQ_A_SEL     8'h08
`define WSQ_A_TIDX    8'h0C
`define WSQ_A_TSTART  8'h10
`define WSQ_A_TLEN    8'h14
`define WSQ_A_TLOOP   8'h18
`define WSQ_A_TFLAG   8'h1C
`define WSQ_A_TIDLE   8'h20
`define WSQ_A_TSLOOP  8'h24
`define WSQ_A_CUR     8'h28

// Control fields
`define WSQ_CTRL_RUN      0
`define WSQ_CTRL_DIV_LSB  1
`define WSQ_CTRL_CLR      3
`define WSQ_CTRL_IDLE_LSB 16
`define WSQ_RST_CTRL      32'h0000_0000

// Status fields
`define WSQ_STAT_VIOL     0
`define WSQ_STAT_ST_LSB   4

// Entry flag fields
`define WSQ_FL_IDLE    0
`define WSQ_FL_ADV_LSB 1
`define WSQ_FL_END     3

// Timing counts in sync clock cycles
`define WSQ_DYN_LAT 9'h100
`define WSQ_LP_MIN  32'h0000_0101
`define WSQ_GAP_CYC 2'h3

`endif

//--- logic/wsq_pkg.sv
package wsq_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		WSQ_GAP,
		WSQ_WAIT,
		WSQ_LOAD,
		WSQ_PLAY,
		WSQ_IDLE
	} wsq_state_e;

	// Segment advancement modes as stored in entry flags
	typedef enum logic [1:0] {
		WSQ_AUTO = 2'h0,
		WSQ_COND = 2'h1,
		WSQ_REP  = 2'h2,
		WSQ_SGL  = 2'h3
	} wsq_adv_e;

endpackage

//--- logic/wsq_playtime.sv
`include "wsq_regs.svh"

module wsq_playtime
	import wsq_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic clr,
	input  wire logic jump,
	input  wire logic tick,
	output logic      met,
	output logic      viol
);

	typedef struct packed {
		logic [31:0] cnt;
		logic        viol;
	} wsq_lp_s;

	wsq_lp_s q;
	wsq_lp_s d;

	// Linear run length in play and idle cycles, restarted by a memory jump
	always_comb begin
		d = q;
		d.viol = 1'b0;
		if (clr) begin
			d.cnt = 32'h0000_0000; // Final group never flagged
		end else if (jump) begin
			d.viol = (q.cnt != 32'h0000_0000) && (q.cnt < `WSQ_LP_MIN);
			d.cnt = {31'h0000_0000, tick};
		end else if (tick && !met) begin
			d.cnt = q.cnt + 32'h0000_0001; // Loops and idle cycles add up
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign met  = q.cnt >= `WSQ_LP_MIN;
	assign viol = q.viol;

endmodule

//--- logic/wsq_sequencer.sv
`include "wsq_regs.svh"

module wsq_sequencer
	import wsq_pkg::*;
#(
	parameter int ENTRIES  = 16,
	parameter int AW       = 24,
	parameter int VEC_LOG2 = 7
)(
	input  wire logic                        clock,
	input  wire logic                        rst_b,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        trig,
	input  wire logic                        adv_evt,
	input  wire logic                        dyn_vld,
	input  wire logic [$clog2(ENTRIES)-1:0]  dyn_idx,
	output logic                             vec_valid,
	output logic      [AW-1:0]               vec_addr,
	output logic                             idle_on,
	output logic      [15:0]                 idle_val,
	output logic      [VEC_LOG2-1:0]         idle_fine,
	output logic                             seq_done
);

	localparam int IW = $clog2(ENTRIES);

	typedef struct packed {
		wsq_state_e        st;
		logic [31:0]       ctrl;
		logic              viol;
		logic [IW-1:0]     sel;
		logic [IW-1:0]     pend;
		logic              pvld;
		logic [8:0]        dcnt;
		logic [IW-1:0]     tidx;
		logic [AW-1:0]     alloc;
		logic [IW-1:0]     ent;
		logic [IW-1:0]     first;
		logic [AW-1:0]     off;
		logic [31:0]       lcnt;
		logic [31:0]       scnt;
		logic [31:0]       icnt;
		logic [VEC_LOG2-1:0] fine;
		logic [AW-1:0]     nxt;
		logic              evt;
		logic [1:0]        gap;
		logic              rdy;
		logic [31:0]       rdat;
		logic              vvld;
		logic [AW-1:0]     vaddr;
		logic              ion;
		logic              done;
	} wsq_core_s;

	wsq_core_s q;
	wsq_core_s d;

	// Entry table memories
	logic [AW-1:0] tbl_start [ENTRIES];
	logic [AW-1:0] tbl_len   [ENTRIES];
	logic [31:0]   tbl_loop  [ENTRIES];
	logic [3:0]    tbl_flag  [ENTRIES];
	logic [31:0]   tbl_idle  [ENTRIES];
	logic [31:0]   tbl_sloop [ENTRIES];

	logic          wr_en;
	logic          rd_en;
	logic          lp_clr;
	logic          lp_jump;
	logic          lp_tick;
	logic          lp_met;
	logic          lp_viol;

	////////////////////////////////////////////////////////////////////////////
	// Playtime tracker

	wsq_playtime u_playtime (
		.clock (clock),
		.rst_b (rst_b),
		.clr   (lp_clr),
		.jump  (lp_jump),
		.tick  (lp_tick),
		.met   (lp_met),
		.viol  (lp_viol)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB access strobes, one wait state

	assign wr_en  = psel && penable && q.rdy && pwrite;
	assign rd_en  = psel && penable && !q.rdy;
	assign pready = q.rdy;
	assign prdata = q.rdat;

	// Unmapped offsets answer with an error
	always_comb begin
		if (paddr > `WSQ_A_CUR || paddr[1:0] != 2'h0) begin
			pslverr = q.rdy;
		end else begin
			pslverr = 1'b0;
		end
	end

	// Table writes land at the table index (TIDX)
	always_ff @(posedge clock) begin
		if (wr_en) begin
			if (paddr == `WSQ_A_TLEN) begin
				tbl_start[q.tidx] <= q.alloc;
				tbl_len[q.tidx]   <= pwdata[AW-1:0];
			end else if (paddr == `WSQ_A_TLOOP) begin
				tbl_loop[q.tidx] <= pwdata;
			end else if (paddr == `WSQ_A_TFLAG) begin
				tbl_flag[q.tidx] <= pwdata[3:0];
			end else if (paddr == `WSQ_A_TIDLE) begin
				tbl_idle[q.tidx] <= pwdata;
			end else if (paddr == `WSQ_A_TSLOOP) begin
				tbl_sloop[q.tidx] <= pwdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Core next-state logic

	always_comb begin
		logic [AW-1:0] e_start;
		logic [AW-1:0] e_len;
		logic [31:0]   e_loop;
		logic [31:0]   s_loop;
		logic          e_idle;
		logic          e_end;
		wsq_adv_e      e_adv;
		logic [33:0]   smp;
		logic [31:0]   cyc;
		logic          last;
		logic          need;
		logic          go_next;
		e_start = tbl_start[q.ent];
		e_len   = tbl_len[q.ent];
		e_loop  = (tbl_loop[q.ent] == 32'h0000_0000) ? 32'h0000_0001 : tbl_loop[q.ent];
		s_loop  = (tbl_sloop[q.first] == 32'h0000_0000) ? 32'h0000_0001 : tbl_sloop[q.first];
		e_idle  = tbl_flag[q.ent][`WSQ_FL_IDLE];
		e_end   = tbl_flag[q.ent][`WSQ_FL_END];
		e_adv   = wsq_adv_e'(tbl_flag[q.ent][`WSQ_FL_ADV_LSB +: 2]);
		smp     = {2'h0, tbl_idle[q.ent]} << q.ctrl[`WSQ_CTRL_DIV_LSB +: 2];
		cyc     = 32'(smp >> VEC_LOG2);
		last    = (q.lcnt + 32'h0000_0001) >= e_loop;
		need    = (e_adv == WSQ_COND) || (e_adv == WSQ_SGL) || (e_adv == WSQ_REP && last);
		go_next = 1'b0;
		d       = q;
		d.done  = 1'b0;
		d.vvld  = 1'b0;
		d.ion   = 1'b0;
		d.rdy   = rd_en;
		lp_clr  = 1'b0;
		lp_jump = 1'b0;
		lp_tick = 1'b0;

		// Register reads
		if (rd_en) begin
			if (paddr == `WSQ_A_CTRL) begin
				d.rdat = q.ctrl;
			end else if (paddr == `WSQ_A_STATUS) begin
				d.rdat = {24'h00_0000, 1'b0, q.st, 3'h0, q.viol};
			end else if (paddr == `WSQ_A_SEL) begin
				d.rdat = 32'(q.sel);
			end else if (paddr == `WSQ_A_TIDX) begin
				d.rdat = 32'(q.tidx);
			end else if (paddr == `WSQ_A_TSTART) begin
				d.rdat = 32'(tbl_start[q.tidx]);
			end else if (paddr == `WSQ_A_TLEN) begin
				d.rdat = 32'(tbl_len[q.tidx]);
			end else if (paddr == `WSQ_A_TLOOP) begin
				d.rdat = tbl_loop[q.tidx];
			end else if (paddr == `WSQ_A_TFLAG) begin
				d.rdat = {28'h000_0000, tbl_flag[q.tidx]};
			end else if (paddr == `WSQ_A_TIDLE) begin
				d.rdat = tbl_idle[q.tidx];
			end else if (paddr == `WSQ_A_TSLOOP) begin
				d.rdat = tbl_sloop[q.tidx];
			end else if (paddr == `WSQ_A_CUR) begin
				d.rdat = {16'h0000, 8'(q.pend), 8'(q.ent)};
			end else begin
				d.rdat = 32'h0000_0000;
			end
		end

		// Register writes
		if (wr_en) begin
			if (paddr == `WSQ_A_CTRL) begin
				d.ctrl = pwdata;
				d.ctrl[`WSQ_CTRL_CLR] = 1'b0;
				if (pwdata[`WSQ_CTRL_CLR]) begin
					d.alloc = '0; // Cleared memory restarts placement
				end
			end else if (paddr == `WSQ_A_SEL) begin
				d.pend = pwdata[IW-1:0];
				d.pvld = 1'b1;
				d.dcnt = `WSQ_DYN_LAT;
			end else if (paddr == `WSQ_A_TIDX) begin
				d.tidx = pwdata[IW-1:0];
			end else if (paddr == `WSQ_A_TLEN) begin
				d.alloc = q.alloc + pwdata[AW-1:0];
			end
		end

		// Port selection overrides a same-cycle software one
		if (dyn_vld) begin
			d.pend = dyn_idx;
			d.pvld = 1'b1;
			d.dcnt = `WSQ_DYN_LAT;
		end else if (q.pvld) begin
			if (q.dcnt != 9'h000) begin
				d.dcnt = q.dcnt - 9'h001;
			end else begin
				d.sel  = q.pend;
				d.pvld = 1'b0;
			end
		end

		// Sticky violation, set beats clear
		if (wr_en && paddr == `WSQ_A_STATUS && pwdata[`WSQ_STAT_VIOL]) begin
			d.viol = 1'b0;
		end
		if (lp_viol) begin
			d.viol = 1'b1;
		end

		// Advancement event latch, set beats consume
		if (adv_evt) begin
			d.evt = 1'b1;
		end

		// Sequencer
		case (q.st)
			WSQ_GAP: begin
				if (q.gap != 2'h0) begin
					d.gap = q.gap - 2'h1;
				end else begin
					d.st = WSQ_WAIT;
				end
			end
			WSQ_WAIT: begin
				if (q.ctrl[`WSQ_CTRL_RUN] && trig) begin
					d.first = q.sel;
					d.ent   = q.sel;
					d.scnt  = 32'h0000_0000;
					d.evt   = adv_evt;
					d.st    = WSQ_LOAD;
					lp_clr  = 1'b1;
				end
			end
			WSQ_LOAD: begin
				d.off  = '0;
				d.lcnt = 32'h0000_0000;
				if (e_idle) begin
					d.icnt = (cyc == 32'h0000_0000) ? 32'h0000_0001 : cyc;
					d.fine = smp[VEC_LOG2-1:0];
					d.st   = WSQ_IDLE;
				end else begin
					lp_jump = (e_start != q.nxt);
					d.st    = WSQ_PLAY;
				end
			end
			WSQ_PLAY: begin
				d.vvld  = 1'b1;
				d.vaddr = e_start + q.off;
				d.nxt   = e_start + q.off + {{(AW-1){1'b0}}, 1'b1};
				lp_tick = 1'b1;
				if (q.off + {{(AW-1){1'b0}}, 1'b1} < e_len) begin
					d.off = q.off + {{(AW-1){1'b0}}, 1'b1};
				end else begin
					d.off = '0;
					if (need && !(q.evt && lp_met)) begin
						d.off = '0; // Replay until the event is latched and playtime is met
					end else begin
						if (need) begin
							d.evt = adv_evt;
						end
						if (last || e_adv == WSQ_COND) begin
							go_next = 1'b1;
						end else begin
							d.lcnt = q.lcnt + 32'h0000_0001;
						end
					end
				end
			end
			WSQ_IDLE: begin
				d.ion   = 1'b1;
				lp_tick = 1'b1;
				if (q.icnt <= 32'h0000_0001) begin
					go_next = 1'b1;
				end else begin
					d.icnt = q.icnt - 32'h0000_0001;
				end
			end
			default: begin
				d.st = WSQ_GAP;
			end
		endcase

		// Step to the following entry, back to the first one, or close the sequence
		if (go_next) begin
			if (e_end) begin
				if ((q.scnt + 32'h0000_0001) >= s_loop) begin
					d.st   = WSQ_GAP;
					d.gap  = `WSQ_GAP_CYC;
					d.done = 1'b1;
					lp_clr = 1'b1;
				end else begin
					d.scnt = q.scnt + 32'h0000_0001;
					d.ent  = q.first;
					d.st   = WSQ_LOAD;
				end
			end else begin
				d.ent = q.ent + {{(IW-1){1'b0}}, 1'b1};
				d.st  = WSQ_LOAD;
			end
		end

		// Stopping generation mid-pass returns to GAP and resets idle logic
		if (!q.ctrl[`WSQ_CTRL_RUN] && q.st != WSQ_GAP && q.st != WSQ_WAIT) begin
			d.st  = WSQ_GAP;
			d.gap = `WSQ_GAP_CYC;
			d.fine = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			q      <= '0;
			q.st   <= WSQ_GAP;
			q.gap  <= `WSQ_GAP_CYC;
			q.ctrl <= `WSQ_RST_CTRL;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign vec_valid = q.vvld;
	assign vec_addr  = q.vaddr;
	assign idle_on   = q.ion;
	assign idle_val  = q.ctrl[`WSQ_CTRL_IDLE_LSB +: 16];
	assign idle_fine = q.fine;
	assign seq_done  = q.done;

endmodule

//--- bench/wsq_seq_sva.sv
`include "wsq_regs.svh"

module wsq_seq_sva
	import wsq_pkg::*;
(
	input wire logic		clock,
	input wire logic		rst_b,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	prdata,
	input wire logic		pready,
	input wire logic		pslverr,
	input wire logic		vec_valid,
	input wire logic		idle_on,
	input wire logic [15:0]	idle_val,
	input wire logic		seq_done
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////
	// Bus access steps
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	sequence s_bad;
		pready && (paddr > `WSQ_A_CUR || paddr[1:0] != 2'h0);
	endsequence

	a_apb_wait: assert property (s_wait |=> pready)
		else $error("bus wait state not one cycle");
	a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
		else $error("ready without a held access");
	a_err_unmapped: assert property (s_bad |-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	a_err_mapped: assert property (pready && !(paddr > `WSQ_A_CUR || paddr[1:0] != 2'h0) |-> !pslverr)
		else $error("mapped access refused");

	////////////////////////////////////////////////////////////////
	// Playback output relations
	a_idle_excl: assert property (idle_on |-> !vec_valid)
		else $error("vector during idle entry");
	a_done_once: assert property (seq_done |=> !seq_done)
		else $error("pass end longer than one cycle");
	a_done_gap: assert property (seq_done |=> (!vec_valid && !idle_on) [*3])
		else $error("output within gap after pass");
	a_idle_val: assert property ($changed(idle_val) |-> $past(pready && pwrite && paddr == `WSQ_A_CTRL))
		else $error("idle value changed without write");
endmodule

bind wsq_sequencer wsq_seq_sva chk_u (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .vec_valid, .idle_on, .idle_val, .seq_done);

//--- bench/wsq_src_model.sv
module wsq_src_model
(
	input wire logic		clock,
	input wire logic		go_trig,
	input wire logic		go_dyn,
	input wire logic [3:0]	dyn_req,
	output logic			trig,
	output logic			adv_evt,
	output logic			dyn_vld,
	output logic [3:0]		dyn_idx = 4'h0
);
	timeunit 1ns;
	timeprecision 1ps;

	// One-cycle pulses, adv_evt held low; select lines keep toggling when not valid
	always @(posedge clock) begin
		trig <= go_trig;
		adv_evt <= 1'b0;
		dyn_vld <= go_dyn;
		dyn_idx <= go_dyn ? dyn_req : ~dyn_idx;
	end
endmodule

//--- bench/waveform_sequencer_idle_playtime_tb.sv
`include "wsq_regs.svh"

module waveform_sequencer_idle_playtime_tb
	import wsq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} wsq_row_s;

	logic			clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic			go_trig = 0, go_dyn = 0, er;
	logic [7:0]		paddr = 0;
	logic [31:0]	pwdata = 0, prdata, rd;
	logic [3:0]		dyn_req = 0, dyn_idx;
	logic			pready, pslverr, trig, adv_evt, dyn_vld, vec_valid, idle_on, seq_done;
	logic [23:0]	vec_addr, la;
	logic [15:0]	idle_val;
	logic [6:0]		idle_fine;
	int				fail_count = 0, tests_run = 0, nv, ni, nd;
	// Entry 1 is a lone idle entry
	wsq_row_s		rows[13] = '{
		'{`WSQ_A_TIDX, 0, 0, 0}, '{`WSQ_A_TLEN, 3, 3, 0}, '{`WSQ_A_TLOOP, 2, 2, 0},
		'{`WSQ_A_TFLAG, 8, 8, 0}, '{`WSQ_A_TSLOOP, 1, 1, 0}, '{`WSQ_A_TSTART, 5, 0, 0},
		'{`WSQ_A_TIDX, 1, 1, 0}, '{`WSQ_A_TFLAG, 9, 9, 0}, '{`WSQ_A_TIDLE, 256, 256, 0},
		'{`WSQ_A_TLOOP, 3, 3, 0}, '{`WSQ_A_TSLOOP, 2, 2, 0}, '{8'h30, 5, 0, 1},
		'{`WSQ_A_CTRL, 32'h1234_0001, 32'h1234_0001, 0}};

	always #2.5 clock = ~clock;

	wsq_sequencer dut_u (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .trig, .adv_evt, .dyn_vld, .dyn_idx, .vec_valid, .vec_addr,
		.idle_on, .idle_val, .idle_fine, .seq_done);
	wsq_src_model src_u (.clock, .go_trig, .go_dyn, .dyn_req, .trig, .adv_evt, .dyn_vld, .dyn_idx);

	////////////////////////////////////////////////////////////////
	// Compare, bus cycle, triggered pass, verdict
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("FAIL %s exp %h got %h", n, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// Trigger only after the previous pass and its gap
	task automatic play(input int cyc);
		go_trig <= 1;
		@(posedge clock);
		go_trig <= 0;
		nv = 0;
		ni = 0;
		nd = 0;
		repeat (cyc) begin
			@(posedge clock);
			nv += (vec_valid === 1'b1);
			ni += (idle_on === 1'b1);
			nd += (seq_done === 1'b1);
			if (vec_valid === 1'b1)
				la = vec_addr;
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (2) @(posedge clock);
		rst_b <= 1;
		@(posedge clock);
		chk("quiet", 32'({vec_valid, idle_on, seq_done, idle_val}), 0);
		foreach (rows[i]) begin
			apb(1, rows[i].a, rows[i].d);
			apb(0, rows[i].a, 0);
			chk("read", rd, rows[i].e);
			chk("err", 32'(er), 32'(rows[i].x));
		end
		chk("idle value", 32'(idle_val), 32'h0000_1234);
		play(40);
		chk("vectors", nv, 6);
		chk("last addr", 32'(la), 2);
		chk("done", nd, 1);
		// Late selection: next trigger still plays the old entry
		go_dyn <= 1;
		dyn_req <= 1;
		@(posedge clock);
		go_dyn <= 0;
		repeat (10) @(posedge clock);
		play(40);
		chk("old kept", nv, 6);
		repeat (260) @(posedge clock);
		for (int k = 0; k < 3; k++) begin
			apb(1, `WSQ_A_CTRL, 32'h1234_0001 | (k << 1));
			play(40);
			chk("idle cycles", ni, 4 << k);
			chk("no vectors", nv, 0);
		end
		// Idle delay with a sub-vector remainder: 200 samples is one cycle plus 72
		apb(1, `WSQ_A_TIDX, 1);
		apb(1, `WSQ_A_TIDLE, 200);
		apb(1, `WSQ_A_CTRL, 32'h1234_0001);
		play(40);
		chk("short idle", ni, 2);
		chk("idle fine", 32'(idle_fine), 72);
		// Entry 2 is small and not ahead of a big one
		// Small entry followed by a non-adjacent one
		apb(1, `WSQ_A_TIDX, 2);
		apb(1, `WSQ_A_TLEN, 5);
		apb(1, `WSQ_A_TFLAG, 0);
		apb(1, `WSQ_A_TLOOP, 1);
		apb(1, `WSQ_A_TSLOOP, 1);
		apb(1, `WSQ_A_CTRL, 32'h1234_0009);
		apb(1, `WSQ_A_TIDX, 3);
		apb(1, `WSQ_A_TLEN, 4);
		apb(1, `WSQ_A_TFLAG, 8);
		apb(1, `WSQ_A_TLOOP, 1);
		apb(0, `WSQ_A_TSTART, 0);
		chk("start", rd, 0);
		apb(1, `WSQ_A_TIDX, 2);
		apb(0, `WSQ_A_TSTART, 0);
		chk("start", rd, 3);
		apb(1, `WSQ_A_SEL, 2);
		repeat (260) @(posedge clock);
		play(40);
		chk("vectors", nv, 9);
		chk("last addr", 32'(la), 3);
		apb(0, `WSQ_A_STATUS, 0);
		chk("violation", rd & 1, 1);
		apb(1, `WSQ_A_STATUS, 1);
		apb(0, `WSQ_A_STATUS, 0);
		chk("cleared", rd & 1, 0);
		test_done;
	end

	// Watchdog
	initial begin
		#20000;
		fail_count++;
		test_done;
	end
endmodule
